// [rtl/dac_channel_control_logic.sv]
// Purpose: Serial word decoder, control registers and double-buffered data of a DAC.
// Assumes: Serial pins and the load strobe are asynchronous and are synchronised here.
// Notes:   The serial clock must be well below a quarter of clk for edge detection.
`include "dac_ctrl_cfg.svh"
// Behaviour
// - global standby bit idles every channel
// - global soft clear clears main data, outputs
// - clear code: midscale twos, bottom offset
// - global clear keeps sub data
// - select bits 0,1 target channel control
// - quad ignores top address bit
// - channel wake low puts channel standby
// - channel clear affects main converter only
// - channel clear applied at next load strobe
// - channel clear code follows coding select
// - bias select field chooses channel bias
// - top word bit picks sub data
// - sub data eight bits, low two ignored
// - offset binary sub code centred 128
// - twos complement sub code signed
// - power-up: standby set, full power set
// - channel control resets wake1 clear1 bias00
// - shift on serial clock fall, MSB first
// - select high bit addresses data registers
// - load strobe fall copies all channels
// - coding select 0 twos, 1 offset
module dac_channel_control_logic #(
	parameter int CHANNELS = 8
) (
	// Clock and reset.
	input  wire logic                  clk,
	input  wire logic                  reset,
	// Serial host link and load strobe, all asynchronous.
	input  wire logic                  serial_clock_in,
	input  wire logic                  frame_sync_in_n,
	input  wire logic                  serial_data_in,
	input  wire logic                  load_outputs_strobe_n,
	// Global state towards the analog side.
	output logic                       reference_on,
	output logic                       coding_select,
	// Per-channel state towards the analog side.
	output dac_ctrl_pkg::chan_out_t    chan_out [`MAX_CH]
);
	dac_ctrl_pkg::state_t st_reg;
	dac_ctrl_pkg::state_t st_next;
	logic        sclk_fall;
	logic        load_outputs_strobe_fall;
	logic        word_done;
	logic [15:0] word;
	logic [2:0]  idx;
	logic [9:0]  clr_code;

	// Next-state logic: synchronisers, shifter, decode and output update.
	always_comb begin
		st_next = st_reg;
		st_next.sclk_s = {st_reg.sclk_s[1:0], serial_clock_in};
		st_next.fs_s = {st_reg.fs_s[0], frame_sync_in_n};
		st_next.serial_data_in_s = {st_reg.serial_data_in_s[0], serial_data_in};
		st_next.load_outputs_strobe_s = {st_reg.load_outputs_strobe_s[1:0], load_outputs_strobe_n};
		sclk_fall = st_reg.sclk_s[2] & ~st_reg.sclk_s[1];
		load_outputs_strobe_fall = st_reg.load_outputs_strobe_s[2] & ~st_reg.load_outputs_strobe_s[1];
		word = {st_reg.shift[14:0], st_reg.serial_data_in_s[1]};
		word_done = 1'b0;
		// A frame is open only while the sync line is low; high aborts it.
		if (st_reg.fs_s[1]) begin
			st_next.count = 4'h0;
		end else if (sclk_fall) begin
			st_next.shift = word;
			if (st_reg.count == `FRAME_LAST) begin
				word_done = 1'b1;
				st_next.count = 4'h0;
			end else begin
				st_next.count = st_reg.count + 4'h1;
			end
		end
		// Quad parts see only the two low address bits.
		if (CHANNELS == 4) begin
			idx = {1'b0, word[`W_ADDR_LO+1:`W_ADDR_LO]};
		end else begin
			idx = word[`W_ADDR_HI:`W_ADDR_LO];
		end
		// Decode the finished word into its target register.
		if (word_done) begin
			if (word[`W_SEL_HI]) begin
				if (word[`W_MAIN_SUB]) begin
					st_next.sub_data[idx] = word[`SUB_HI:`SUB_LO];
				end else begin
					st_next.main_data[idx] = word[`MAIN_HI:0];
				end
			end else if (word[`W_SEL_LO]) begin
				st_next.ctrl[idx].wake = word[`CH_WAKE];
				st_next.ctrl[idx].soft_clear = word[`CH_CLR];
				st_next.ctrl[idx].bias_sel = word[`CH_MX_HI:`CH_MX_LO];
			end else begin
				// No address is looked at here.
				st_next.run = word[`SYS_RUN];
				st_next.channel_wake = word[`SYS_CHANNEL_WAKE];
				st_next.coding = word[`SYS_CODING];
				st_next.glob_clear = word[`SYS_GLOBAL_SOFT_CLEAR];
			end
		end
		clr_code = st_next.coding ? `CLEAR_OFFS : `CLEAR_TWOS;
		// The strobe moves every channel at once; a channel clear waits for it.
		if (load_outputs_strobe_fall) begin
			for (int c = 0; c < `MAX_CH; c++) begin
				if (st_next.ctrl[c].soft_clear) begin
					st_next.main_data[c] = clr_code;
				end
				st_next.main_out[c] = st_next.main_data[c];
				st_next.sub_out[c] = st_next.sub_data[c];
			end
		end
		// Global clear holds main converters cleared and never touches sub data.
		if (st_next.glob_clear) begin
			for (int c = 0; c < `MAX_CH; c++) begin
				st_next.main_data[c] = clr_code;
				st_next.main_out[c] = clr_code;
			end
		end
		// Power-up: reference running, all channels standby.
		if (reset) begin
			st_next = '0;
			st_next.sclk_s = 3'h7;
			st_next.fs_s = 2'h3;
			st_next.load_outputs_strobe_s = 3'h7;
			st_next.run = `RST_RUN;
			st_next.channel_wake = `RST_CHANNEL_WAKE;
			st_next.coding = `RST_CODING;
			st_next.glob_clear = `RST_GLOBAL_SOFT_CLEAR;
			for (int c = 0; c < `MAX_CH; c++) begin
				st_next.ctrl[c].wake = `RST_WAKE;
				st_next.ctrl[c].soft_clear = `RST_CLR;
				st_next.ctrl[c].bias_sel = `RST_MX;
			end
		end
	end

	// The single state register.
	always_ff @(posedge clk) begin
		st_reg <= st_next;
	end

	// Outputs are decoded straight from registered state.
	always_comb begin
		reference_on = st_reg.run;
		coding_select = st_reg.coding;
		for (int c = 0; c < `MAX_CH; c++) begin
			chan_out[c].active = st_reg.run & ~st_reg.channel_wake & st_reg.ctrl[c].wake;
			chan_out[c].bias_sel = st_reg.ctrl[c].bias_sel;
			chan_out[c].main_code = st_reg.main_out[c];
			if (st_reg.coding) begin
				chan_out[c].sub_offset = $signed({1'b0, st_reg.sub_out[c]} - `SUB_MID);
			end else begin
				chan_out[c].sub_offset = $signed({st_reg.sub_out[c][7], st_reg.sub_out[c]});
			end
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	// Checks on the behaviour above.
	power_up_a: assert property ($past(reset) |-> st_reg.channel_wake && st_reg.run
		&& st_reg.ctrl[0].wake && st_reg.ctrl[0].soft_clear && st_reg.ctrl[0].bias_sel == 2'h0)
		else $error("power-up state wrong");
	all_standby_a: assert property (st_reg.channel_wake |-> !chan_out[0].active && !chan_out[3].active)
		else $error("channel active during global standby");
	chan_wake_a: assert property (!st_reg.ctrl[1].wake |-> !chan_out[1].active)
		else $error("channel active while wake is low");
	glob_clear_a: assert property (st_reg.glob_clear |-> st_reg.main_out[2] ==
		(st_reg.coding ? `CLEAR_OFFS : `CLEAR_TWOS)) else $error("global clear code wrong");
	sub_keep_a: assert property (st_reg.glob_clear && !word_done |=> $stable(st_reg.sub_data))
		else $error("global clear altered sub data");
	sub_write_a: assert property (word_done && word[15] && word[13] |=>
		st_reg.sub_data[$past(idx)] == $past(word[9:2])) else $error("sub write wrong");
	chan_write_a: assert property (word_done && word[14:13] == 2'h2 |=>
		st_reg.ctrl[$past(idx)].wake == $past(word[4])) else $error("channel write wrong");
	load_outputs_strobe_copy_a: assert property (load_outputs_strobe_fall && !st_next.glob_clear && !st_reg.ctrl[0].soft_clear
		&& !word_done |=> st_reg.main_out[0] == $past(st_reg.main_data[0]))
		else $error("load strobe did not copy");
	chan_clear_a: assert property (load_outputs_strobe_fall && st_reg.ctrl[0].soft_clear && !word_done |=>
		st_reg.main_out[0] == (st_reg.coding ? `CLEAR_OFFS : `CLEAR_TWOS))
		else $error("channel clear not applied");
	frame_only_a: assert property (!word_done |=> $stable(st_reg.coding) && $stable(st_reg.channel_wake))
		else $error("control changed without a full word");
	quad_addr_a: assert property (CHANNELS == 4 |-> idx[2] == 1'b0)
		else $error("quad decode used top address bit");

	// Power-up leaves the outputs, the coding and the bit counter in known places.
	// The last channel is checked too, so a short reset loop would show up here.
	reset_outputs_a: assert property ($past(reset) |-> !st_reg.glob_clear
		&& st_reg.main_out == '0 && st_reg.sub_out == '0) else $error("power-up outputs wrong");
	reset_coding_a: assert property ($past(reset) |-> !st_reg.coding && st_reg.count == 4'h0)
		else $error("power-up coding or count wrong");
	reset_ctrl_all_a: assert property ($past(reset) |-> st_reg.ctrl[7].wake
		&& st_reg.ctrl[7].soft_clear && st_reg.ctrl[7].bias_sel == 2'h0)
		else $error("power-up channel control wrong");

	// The shifter moves only on a serial clock fall inside an open frame.
	shift_step_a: assert property (sclk_fall && !st_reg.fs_s[1] |=>
		st_reg.shift == $past(word)) else $error("serial bit not shifted");
	shift_hold_a: assert property (!sclk_fall || st_reg.fs_s[1] |=>
		$stable(st_reg.shift)) else $error("shifter moved outside a clock fall");

	// A high sync line throws away a partial word, so a cut frame cannot
	// leave stale bits that a later frame would complete by accident.
	frame_abort_a: assert property (st_reg.fs_s[1] |=> st_reg.count == 4'h0)
		else $error("count kept after frame abort");
	count_step_a: assert property (sclk_fall && !st_reg.fs_s[1] && st_reg.count != `FRAME_LAST |=>
		st_reg.count == $past(st_reg.count) + 4'h1) else $error("bit count did not advance");
	word_end_a: assert property (word_done |-> st_reg.count == `FRAME_LAST && sclk_fall)
		else $error("word applied before sixteen bits");
	count_wrap_a: assert property (word_done |=> st_reg.count == 4'h0)
		else $error("count did not restart after a word");

	// Global control words land whole and leave every channel control register alone.
	sys_write_a: assert property (word_done && word[14:13] == 2'h0 |=>
		st_reg.channel_wake == $past(word[`SYS_CHANNEL_WAKE]) && st_reg.run == $past(word[`SYS_RUN]))
		else $error("global control write wrong");
	coding_write_a: assert property (word_done && word[14:13] == 2'h0 |=>
		st_reg.coding == $past(word[`SYS_CODING])) else $error("coding select write wrong");
	sys_clear_write_a: assert property (word_done && word[14:13] == 2'h0 |=>
		st_reg.glob_clear == $past(word[`SYS_GLOBAL_SOFT_CLEAR])) else $error("global clear write wrong");
	sys_no_addr_a: assert property (word_done && word[14:13] == 2'h0 |=>
		$stable(st_reg.ctrl)) else $error("global write touched a channel");

	// Channel control words reach only the addressed channel's fields.
	chan_bias_a: assert property (word_done && word[14:13] == 2'h2 |=>
		st_reg.ctrl[$past(idx)].bias_sel == $past(word[`CH_MX_HI:`CH_MX_LO]))
		else $error("bias select write wrong");
	chan_clear_bit_a: assert property (word_done && word[14:13] == 2'h2 |=>
		st_reg.ctrl[$past(idx)].soft_clear == $past(word[`CH_CLR]))
		else $error("channel clear bit write wrong");
	chan_keep_sys_a: assert property (word_done && word[14:13] == 2'h2 |=>
		$stable(st_reg.channel_wake) && $stable(st_reg.coding) && $stable(st_reg.glob_clear))
		else $error("channel write touched global control");

	// Data words go to main or sub data by the top bit, whatever the low select bit.
	main_write_a: assert property (word_done && word[13] && !word[15] && !load_outputs_strobe_fall
		&& !st_next.glob_clear |=> st_reg.main_data[$past(idx)] == $past(word[`MAIN_HI:0]))
		else $error("main data write wrong");
	main_keep_sub_a: assert property (word_done && word[13] && !word[15] |=>
		$stable(st_reg.sub_data)) else $error("main write altered sub data");
	data_no_ctrl_a: assert property (word_done && word[13] |=> $stable(st_reg.ctrl))
		else $error("data write touched channel control");

	// Outputs move only on the strobe or under a global clear; sub data rides along.
	load_outputs_strobe_sub_a: assert property (load_outputs_strobe_fall && !word_done |=>
		st_reg.sub_out[1] == $past(st_reg.sub_data[1])) else $error("sub data not loaded");
	out_hold_a: assert property (!load_outputs_strobe_fall && !st_next.glob_clear |=>
		$stable(st_reg.main_out) && $stable(st_reg.sub_out)) else $error("outputs moved idle");

	// A channel clear hits the main converter only, with the code of the coding.
	chan_clear_sub_a: assert property (load_outputs_strobe_fall && st_reg.ctrl[0].soft_clear && !word_done |=>
		st_reg.sub_out[0] == $past(st_reg.sub_data[0])) else $error("channel clear hit sub");
	chan_clear_data_a: assert property (load_outputs_strobe_fall && st_reg.ctrl[0].soft_clear && !word_done |=>
		st_reg.main_data[0] == (st_reg.coding ? `CLEAR_OFFS : `CLEAR_TWOS))
		else $error("channel clear left main data");

	// A global clear holds main data and outputs of every channel at the clear code.
	glob_data_a: assert property (st_reg.glob_clear |-> st_reg.main_data[5] ==
		(st_reg.coding ? `CLEAR_OFFS : `CLEAR_TWOS)) else $error("global clear left main data");
	glob_out_all_a: assert property (st_reg.glob_clear |-> st_reg.main_out[7] ==
		(st_reg.coding ? `CLEAR_OFFS : `CLEAR_TWOS)) else $error("global clear left an output");

	// Sub code meaning follows the coding select.
	sub_mid_a: assert property (st_reg.coding && st_reg.sub_out[2] == 8'h80 |->
		chan_out[2].sub_offset == 9'h000) else $error("offset sub centre wrong");
	sub_sign_a: assert property (!st_reg.coding |->
		chan_out[2].sub_offset[8] == st_reg.sub_out[2][7]) else $error("twos sub sign wrong");
	wake_active_a: assert property (st_reg.run && !st_reg.channel_wake && st_reg.ctrl[6].wake |->
		chan_out[6].active) else $error("woken channel not active");

	wake_up_c: cover property ($fell(st_reg.channel_wake));
	data_write_c: cover property (word_done && word[13]);
	load_outputs_strobe_c: cover property (load_outputs_strobe_fall && !st_reg.ctrl[0].soft_clear);
	glob_clear_c: cover property ($rose(st_reg.glob_clear));
	chan_clear_c: cover property (load_outputs_strobe_fall && st_reg.ctrl[2].soft_clear);
endmodule

// [rtl/dac_ctrl_cfg.svh]
// Purpose: Constants for the serial DAC channel control logic.
// Assumes: 16-bit serial words, bit 15 shifted first.
// Notes:   Bit positions, reset values and clear codes live here only.
`ifndef DAC_CTRL_CFG_SVH
`define DAC_CTRL_CFG_SVH
// Array sizes and word framing.
`define MAX_CH          8
`define FRAME_LAST      4'hF
// Common word fields.
`define W_MAIN_SUB      15
`define W_SEL_LO        14
`define W_SEL_HI        13
`define W_ADDR_HI       12
`define W_ADDR_LO       10
// Global control fields.
`define SYS_CODING      6
`define SYS_RUN         5
`define SYS_CHANNEL_WAKE        4
`define SYS_GLOBAL_SOFT_CLEAR        3
// Per-channel control fields.
`define CH_MX_HI        9
`define CH_MX_LO        8
`define CH_WAKE         4
`define CH_CLR          3
// Data fields.
`define MAIN_HI         9
`define SUB_HI          9
`define SUB_LO          2
// Clear codes: signed zero is midscale, offset-binary zero is the bottom.
`define CLEAR_TWOS      10'h000
`define CLEAR_OFFS      10'h000
`define SUB_MID         9'h080
// Power-up values.
`define RST_RUN         1'h1
`define RST_CHANNEL_WAKE        1'h1
`define RST_CODING      1'h0
`define RST_GLOBAL_SOFT_CLEAR        1'h0
`define RST_WAKE        1'h1
`define RST_CLR         1'h1
`define RST_MX          2'h0
`endif

// [rtl/dac_ctrl_pkg.sv]
// Purpose: Types for the serial DAC channel control logic.
// Assumes: dac_ctrl_cfg.svh supplies the sizes.
// Notes:   All module state is one packed struct.
`include "dac_ctrl_cfg.svh"
package dac_ctrl_pkg;
	// Per-channel control register.
	typedef struct packed {
		logic       wake;
		logic       soft_clear;
		logic [1:0] bias_sel;
	} chan_ctrl_t;
	// What each converter presents to the analog side.
	typedef struct packed {
		logic              active;
		logic [1:0]        bias_sel;
		logic [9:0]        main_code;
		logic signed [8:0] sub_offset;
	} chan_out_t;
	// Whole state of the control block.
	typedef struct packed {
		logic [2:0]                     sclk_s;
		logic [1:0]                     fs_s;
		logic [1:0]                     serial_data_in_s;
		logic [2:0]                     load_outputs_strobe_s;
		logic [15:0]                    shift;
		logic [3:0]                     count;
		logic                           run;
		logic                           channel_wake;
		logic                           coding;
		logic                           glob_clear;
		chan_ctrl_t [`MAX_CH-1:0]       ctrl;
		logic [`MAX_CH-1:0][9:0]        main_data;
		logic [`MAX_CH-1:0][7:0]        sub_data;
		logic [`MAX_CH-1:0][9:0]        main_out;
		logic [`MAX_CH-1:0][7:0]        sub_out;
	} state_t;
endpackage

// [bench/host_serial_model.sv]
// Purpose: Host model that drives the serial word link and the load strobe.
// Assumes: Link clock period 125 ns; the link clock rests high between frames.
// Notes:   After a frame the data line shows the inverse of its last bit.
module host_serial_model;
	timeunit 1ns;
	timeprecision 100ps;
	logic serial_clock_in       = 1'b1;
	logic frame_sync_in_n       = 1'b1;
	logic serial_data_in        = 1'b0;
	logic load_outputs_strobe_n = 1'b1;
	// Each bit is set up half a period before its falling edge and held after it.
	task automatic send(input logic [15:0] word);
		frame_sync_in_n = 1'b0;
		for (int i = 15; i >= 0; i--) begin
			serial_data_in = word[i];
			#62.5 serial_clock_in = 1'b0;
			#62.5 serial_clock_in = 1'b1;
		end
		#62.5 frame_sync_in_n = 1'b1;
		serial_data_in = ~serial_data_in;
	endtask
	// The strobe is pulsed after every register change that must reach the outputs.
	task automatic strobe();
		load_outputs_strobe_n = 1'b0;
		#62.5 load_outputs_strobe_n = 1'b1;
	endtask
endmodule

// [bench/dac_channel_control_logic_tb.sv]
// Purpose: Self-checking bench for the DAC channel control logic.
// Assumes: Register updates settle within ten clocks after a frame.
// Notes:   Waits are fixed counts; a watchdog cuts a hang short.
`include "dac_ctrl_cfg.svh"
module dac_channel_control_logic_tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic                    clk          = 1'b0;
	logic                    reset        = 1'b1;
	logic                    reference_on;
	logic                    coding_select;
	dac_ctrl_pkg::chan_out_t chan_out [`MAX_CH];
	int                      n_fail       = 0;
	int                      total_checks = 0;
	logic [15:0]             bias_words [3] = '{16'h4910, 16'h5210, 16'h5710};
	// Clock of 8 ns.
	always #4 clk = ~clk;
	host_serial_model host_u ();
	dac_channel_control_logic #(.CHANNELS(8)) dut_u (
		.clk                   (clk),
		.reset                 (reset),
		.serial_clock_in       (host_u.serial_clock_in),
		.frame_sync_in_n       (host_u.frame_sync_in_n),
		.serial_data_in        (host_u.serial_data_in),
		.load_outputs_strobe_n (host_u.load_outputs_strobe_n),
		.reference_on          (reference_on),
		.coding_select         (coding_select),
		.chan_out              (chan_out)
	);
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic settle(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic write(input logic [15:0] word);
		host_u.send(word);
		settle(10);
	endtask
	task automatic load();
		host_u.strobe();
		settle(8);
	endtask
	task automatic conclude();
		$display("checks %0d failures %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	// Power-up state before any word is sent.
	task automatic test_reset();
		check(reference_on, 1'b1);
		check(coding_select, 1'b0);
		for (int c = 0; c < 8; c++) begin
			check(chan_out[c].active, 1'b0);
			check(chan_out[c].bias_sel, 2'h0);
			check(chan_out[c].main_code, 10'h000);
		end
		$display("test reset done");
	endtask
	// Leaving standby with offset binary coding, then every bias code.
	task automatic test_setup();
		write(16'h0060);
		check(coding_select, 1'b1);
		check(chan_out[7].active, 1'b1);
		for (int i = 0; i < 3; i++) begin
			write(bias_words[i]);
		end
		write(16'h4C00);
		check(chan_out[2].bias_sel, 2'h1);
		check(chan_out[4].bias_sel, 2'h2);
		check(chan_out[5].bias_sel, 2'h3);
		check(chan_out[1].bias_sel, 2'h0);
		check(chan_out[3].active, 1'b0);
		$display("test setup done");
	endtask
	// Data words stay buffered until the strobe.
	task automatic test_data();
		write(16'h2955);
		write(16'hEB0F);
		check(chan_out[2].main_code, 10'h000);
		load();
		check(chan_out[2].main_code, 10'h155);
		check(chan_out[2].sub_offset, 9'h043);
		check(chan_out[0].main_code, 10'h000);
		write(16'h4918);
		check(chan_out[2].main_code, 10'h155);
		load();
		check(chan_out[2].main_code, 10'h000);
		check(chan_out[2].sub_offset, 9'h043);
		$display("test data done");
	endtask
	// Global clear under twos complement, then global standby.
	task automatic test_global();
		write(16'h4410);
		write(16'h26AA);
		load();
		check(chan_out[1].main_code, 10'h2AA);
		write(16'h0028);
		check(chan_out[1].main_code, 10'h000);
		check({7'h00, chan_out[2].sub_offset}, 9'h1C3);
		write(16'h0030);
		check(chan_out[1].active, 1'b0);
		write(16'h0020);
		check(chan_out[1].active, 1'b1);
		$display("test global done");
	endtask
	// Watchdog against a hang.
	initial begin
		#200us;
		n_fail++;
		conclude();
	end
	initial begin
		settle(4);
		reset = 1'b0;
		settle(3);
		test_reset();
		test_setup();
		test_data();
		test_global();
		conclude();
	end
endmodule
